// >>> pkg/unrf_pkg.sv
// Constants, types and register map of the nine-bit receive filter.
// Assumes an 8-bit register port and a 16x oversampling tick.
package unrf_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register port
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    typedef logic [ADDR_W-1:0] unrf_addr_t;
    typedef logic [DATA_W-1:0] unrf_data_t;

    localparam unrf_addr_t OFS_CTRL = 3'h0;
    localparam unrf_addr_t OFS_SER_BUF = 3'h1;
    localparam unrf_addr_t OFS_BAUD_LO = 3'h2;
    localparam unrf_addr_t OFS_BAUD_HI = 3'h3;
    localparam unrf_addr_t OFS_IRQ_STAT = 3'h4;
    localparam unrf_addr_t OFS_IRQ_MASK = 3'h5;

    // Fields of serial_control_reg
    localparam int CTRL_MODE_HI = 7;
    localparam int CTRL_MODE_LO = 6;
    localparam int CTRL_FILTER = 5;
    localparam int CTRL_RX_EN = 4;
    localparam int CTRL_BUSY = 3;
    localparam int CTRL_NINTH = 2;
    localparam int CTRL_FLAG = 0;

    // Fields of the interrupt status and mask registers
    localparam int IRQ_LOADED = 0;
    localparam int IRQ_DISCARD = 1;
    localparam int IRQ_REJECT = 2;
    localparam int IRQ_W = 3;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam unrf_data_t CTRL_RST = 8'h00;
    localparam unrf_data_t SER_BUF_RST = 8'h00;
    localparam logic [15:0] BAUD_DIV_RST = 16'h0040;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
    localparam logic [8:0] SHIFT_PRELOAD = 9'h1ff;

    ////////////////////////////////////////////////////////////////////////
    // Timing: sample phases of the divide-by-16 bit counter and last count of the tail counter
    localparam logic [3:0] PH_FIRST = 4'h7;
    localparam logic [3:0] PH_MID = 4'h8;
    localparam logic [3:0] PH_LAST = 4'h9;
    localparam logic [3:0] TAIL_LAST = 4'hf;

    // Serial modes
    localparam logic [1:0] MODE_0 = 2'h0;
    localparam logic [1:0] MODE_1 = 2'h1;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RECV = 3'b010,
        ST_TAIL = 3'b100
    } unrf_state_e;

endpackage

// >>> pkg/unrf_samp_if.sv
// Bundle between the receive control and the majority bit voter.
// Assumes one clock domain; the tick is a one-cycle enable.
`timescale 1ns/10ps
`default_nettype none
interface unrf_samp_if;
    logic tick;
    logic [3:0] phase;
    logic line;
    logic vote_valid;
    logic vote_bit;

    modport ctrl (output tick, output phase, output line,
                  input vote_valid, input vote_bit);
    modport voter (input tick, input phase, input line,
                   output vote_valid, output vote_bit);
endinterface
`default_nettype wire

// >>> rtl/unrf_baud_div.sv
// Oversampling divider: one-cycle tick every (divisor + 1) clocks.
// Assumes the divisor is held steady by software between frames.
`timescale 1ns/10ps
`default_nettype none
module unrf_baud_div #(
    parameter int DIV_W = 16
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic [DIV_W-1:0] divisor,
    output logic tick_ff
);
    logic [DIV_W-1:0] count_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= '0;
            tick_ff <= 1'b0;
        end else if (count_ff >= divisor) begin
            count_ff <= '0;
            tick_ff <= 1'b1;
        end else begin
            count_ff <= count_ff + 1'b1;
            tick_ff <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// >>> rtl/unrf_bit_voter.sv
// Two-of-three bit detector on the receive line.
// Assumes the phase counter advances once per tick.
`timescale 1ns/10ps
`default_nettype none
module unrf_bit_voter
    import unrf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    unrf_samp_if.voter sif
);
    logic s_first_ff;
    logic s_mid_ff;
    logic valid_ff;
    logic bit_ff;

    assign sif.vote_valid = valid_ff;
    assign sif.vote_bit = bit_ff;

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_first_ff <= 1'b1;
            s_mid_ff <= 1'b1;
        end else if (sif.tick && sif.phase == PH_FIRST) begin
            s_first_ff <= sif.line;
        end else if (sif.tick && sif.phase == PH_MID) begin
            s_mid_ff <= sif.line;
        end
    end

    // Majority of the three samples
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            valid_ff <= 1'b0;
            bit_ff <= 1'b1;
        end else begin
            valid_ff <= sif.tick && sif.phase == PH_LAST;
            if (sif.tick && sif.phase == PH_LAST) begin
                bit_ff <= (s_first_ff & s_mid_ff) | (s_first_ff & sif.line) |
                          (s_mid_ff & sif.line);
            end
        end
    end
endmodule
`default_nettype wire

// >>> rtl/unrf_rx_filter.sv
// Receive completion and address filter of a nine-bit frame UART.
// Assumes rxd and the register port are synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Each accepted bit enters the shift register at the right end.
// - Nine-bit register; start at leftmost position triggers final shift.
// - Load only if flag clear and (mode zero, filter off or ninth bit one).
// - Failed condition: frame dropped, buffer and ninth bit kept, no flag.
// - On load, ninth bit to its holder, eight data bits to buffer.
// - One bit time after final shift, watch again for falling edge.
// - Modes two and three carry nine data bits; ninth kept in status.
// - Mode zero ignores the address filter enable.
// - Mode one with filter on needs a high ninth bit.
// - Frame: low start, eight data LSB first, ninth bit, high stop.
// - Start edge resets the bit counter and presets shift register ones.
// - Line sampled at phases seven, eight, nine; majority accepted.
// - First bit not zero: reception abandoned, edge search resumes.
module unrf_rx_filter
    import unrf_pkg::*;
#(
    parameter logic [15:0] BAUD_DIV_RESET = unrf_pkg::BAUD_DIV_RST
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic rxd,
    input wire unrf_pkg::unrf_addr_t reg_addr,
    input wire unrf_pkg::unrf_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output unrf_pkg::unrf_data_t reg_rdata_ff,
    output logic irq_ff,
    output logic rx_int_req_ff
);
    import unrf_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    unrf_state_e state_ff;
    unrf_state_e nxt_state;
    logic [1:0] mode_ff;
    logic address_filter_enable_ff;
    logic rx_enable_ff;
    logic receive_done_flag_ff;
    logic nxt_receive_done_flag;
    logic received_ninth_bit_ff;
    unrf_data_t serial_buffer_ff;
    logic [15:0] baud_div_ff;
    logic [IRQ_W-1:0] irq_stat_ff;
    logic [IRQ_W-1:0] nxt_irq_stat;
    logic [IRQ_W-1:0] irq_mask_ff;
    logic [8:0] shift_ff;
    logic [3:0] phase_ff;
    logic [3:0] tail_cnt_ff;
    logic line_prev_ff;
    logic tick;
    logic start_edge;
    logic first_bit;
    logic final_shift;
    logic filter_pass;
    logic load_frame;
    logic ev_loaded;
    logic ev_discard;
    logic ev_reject;
    logic wr_ctrl;
    logic rd_irq_stat;
    unrf_data_t frame_byte;
    unrf_data_t ctrl_view;

    unrf_samp_if sif ();

    ////////////////////////////////////////////////////////////////////////
    // Oversampling tick and bit voter
    unrf_baud_div #(
        .DIV_W(16)
    ) u_baud_div (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .divisor(baud_div_ff),
        .tick_ff(tick)
    );

    assign sif.tick = tick;
    assign sif.phase = phase_ff;
    assign sif.line = rxd;

    unrf_bit_voter u_bit_voter (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .sif(sif)
    );

    ////////////////////////////////////////////////////////////////////////
    // Frame decode
    always_comb begin
        for (int i = 0; i < DATA_W; i++) begin
            frame_byte[i] = shift_ff[DATA_W-1-i];
        end
    end

    assign start_edge = tick && line_prev_ff && !rxd && rx_enable_ff;
    assign first_bit = sif.vote_valid && shift_ff == SHIFT_PRELOAD;
    // Start bit sits at the left end before the last shift
    assign final_shift = sif.vote_valid && !first_bit
                         && !shift_ff[8];
    // Mode 0 skips the filter; other modes with the filter on need the ninth bit high
    assign filter_pass = (mode_ff == MODE_0) || !address_filter_enable_ff
                         || sif.vote_bit;
    assign load_frame = state_ff == ST_RECV && final_shift
                        && !receive_done_flag_ff && filter_pass;
    assign ev_loaded = load_frame;
    assign ev_discard = state_ff == ST_RECV && final_shift
                        && !load_frame;
    assign ev_reject = state_ff == ST_RECV && first_bit
                       && sif.vote_bit;

    ////////////////////////////////////////////////////////////////////////
    // Receive sequencer
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (start_edge) begin
                    nxt_state = ST_RECV;
                end
            end
            ST_RECV: begin
                if (ev_reject) begin
                    nxt_state = ST_IDLE;
                end else if (final_shift) begin
                    nxt_state = ST_TAIL;
                end
            end
            ST_TAIL: begin
                if (tick && tail_cnt_ff == TAIL_LAST) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= ST_IDLE;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Line history for falling edge search
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            line_prev_ff <= 1'b1;
        end else if (tick) begin
            line_prev_ff <= rxd;
        end
    end

    // Divide-by-16 bit counter
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_ff <= '0;
        end else if (state_ff == ST_IDLE && start_edge) begin
            phase_ff <= '0;
        end else if (tick && state_ff != ST_IDLE) begin
            phase_ff <= phase_ff + 1'b1;
        end
    end

    // One bit time after the final shift
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            tail_cnt_ff <= '0;
        end else if (state_ff != ST_TAIL) begin
            tail_cnt_ff <= '0;
        end else if (tick) begin
            tail_cnt_ff <= tail_cnt_ff + 1'b1;
        end
    end

    // Input shift register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            shift_ff <= SHIFT_PRELOAD;
        end else if (state_ff == ST_IDLE && start_edge) begin
            shift_ff <= SHIFT_PRELOAD;
        end else if (state_ff == ST_RECV && sif.vote_valid && !ev_reject) begin
            shift_ff <= {shift_ff[7:0], sif.vote_bit};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Received data holders
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            serial_buffer_ff <= SER_BUF_RST;
            received_ninth_bit_ff <= 1'b0;
        end else if (load_frame) begin
            serial_buffer_ff <= frame_byte;
            received_ninth_bit_ff <= sif.vote_bit;
        end
    end

    // Receive done flag: hardware set wins over a software clear
    assign wr_ctrl = reg_wr && reg_addr == OFS_CTRL;

    always_comb begin
        nxt_receive_done_flag = receive_done_flag_ff;
        if (wr_ctrl) begin
            nxt_receive_done_flag = reg_wdata[CTRL_FLAG];
        end
        if (load_frame) begin
            nxt_receive_done_flag = 1'b1;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            receive_done_flag_ff <= CTRL_RST[CTRL_FLAG];
            rx_int_req_ff <= 1'b0;
        end else begin
            receive_done_flag_ff <= nxt_receive_done_flag;
            rx_int_req_ff <= nxt_receive_done_flag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software control
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mode_ff <= CTRL_RST[CTRL_MODE_HI:CTRL_MODE_LO];
            address_filter_enable_ff <= CTRL_RST[CTRL_FILTER];
            rx_enable_ff <= CTRL_RST[CTRL_RX_EN];
        end else if (wr_ctrl) begin
            mode_ff <= reg_wdata[CTRL_MODE_HI:CTRL_MODE_LO];
            address_filter_enable_ff <= reg_wdata[CTRL_FILTER];
            rx_enable_ff <= reg_wdata[CTRL_RX_EN];
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            baud_div_ff <= BAUD_DIV_RESET;
        end else if (reg_wr && reg_addr == OFS_BAUD_LO) begin
            baud_div_ff[7:0] <= reg_wdata;
        end else if (reg_wr && reg_addr == OFS_BAUD_HI) begin
            baud_div_ff[15:8] <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_mask_ff <= IRQ_MASK_RST;
        end else if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
            irq_mask_ff <= reg_wdata[IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event status, cleared by reading, new events win
    assign rd_irq_stat = reg_rd && reg_addr == OFS_IRQ_STAT;

    always_comb begin
        nxt_irq_stat = rd_irq_stat ? '0 : irq_stat_ff;
        nxt_irq_stat[IRQ_LOADED] = nxt_irq_stat[IRQ_LOADED] | ev_loaded;
        nxt_irq_stat[IRQ_DISCARD] = nxt_irq_stat[IRQ_DISCARD] | ev_discard;
        nxt_irq_stat[IRQ_REJECT] = nxt_irq_stat[IRQ_REJECT] | ev_reject;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_stat_ff <= '0;
            irq_ff <= 1'b0;
        end else begin
            irq_stat_ff <= nxt_irq_stat;
            irq_ff <= |(nxt_irq_stat & irq_mask_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port, data one cycle after the strobe
    always_comb begin
        ctrl_view = '0;
        ctrl_view[CTRL_MODE_HI:CTRL_MODE_LO] = mode_ff;
        ctrl_view[CTRL_FILTER] = address_filter_enable_ff;
        ctrl_view[CTRL_RX_EN] = rx_enable_ff;
        ctrl_view[CTRL_BUSY] = state_ff != ST_IDLE;
        ctrl_view[CTRL_NINTH] = received_ninth_bit_ff;
        ctrl_view[CTRL_FLAG] = receive_done_flag_ff;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata_ff <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                OFS_CTRL: reg_rdata_ff <= ctrl_view;
                OFS_SER_BUF: reg_rdata_ff <= serial_buffer_ff;
                OFS_BAUD_LO: reg_rdata_ff <= baud_div_ff[7:0];
                OFS_BAUD_HI: reg_rdata_ff <= baud_div_ff[15:8];
                OFS_IRQ_STAT: reg_rdata_ff <= {5'h00, irq_stat_ff};
                OFS_IRQ_MASK: reg_rdata_ff <= {5'h00, irq_mask_ff};
                default: reg_rdata_ff <= '0;
            endcase
        end else begin
            reg_rdata_ff <= '0;
        end
    end
endmodule
`default_nettype wire

// >>> dv/unrf_remote_tx.sv
// Remote nine-bit transmitter that drives the receive line.
// Assumes its tasks are called right after a rising edge.
`timescale 1ns/10ps
`default_nettype none
module unrf_remote_tx #(
    parameter int BIT_CLKS = 16
) (
    input wire logic core_clk,
    output var logic rxd
);
    // Line idles high as with a pull-up
    initial rxd = 1'b1;
    task automatic send(input logic [7:0] d, input logic b9);
        logic [11:0] fr;
        // Start low, data lsb first, ninth bit, stop and idle high
        fr = {2'b11, b9, d, 1'b0};
        for (int i = 0; i < 12; i++) begin
            rxd <= fr[i];
            repeat (BIT_CLKS) @(posedge core_clk);
        end
    endtask
    // Short low pulse that must not pass as a start bit
    task automatic glitch(input int n);
        rxd <= 1'b0;
        repeat (n) @(posedge core_clk);
        rxd <= 1'b1;
        repeat (2 * BIT_CLKS) @(posedge core_clk);
    endtask
endmodule
`default_nettype wire

// >>> dv/unrf_rx_filter_assertions.sv
// Port checker of the nine-bit receive filter.
// Assumes one clock domain; bound to the filter top below.
`timescale 1ns/10ps
`default_nettype none
module unrf_rx_filter_assertions
    import unrf_pkg::*;
(
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic rxd,
    input wire unrf_pkg::unrf_addr_t reg_addr,
    input wire unrf_pkg::unrf_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire unrf_pkg::unrf_data_t reg_rdata_ff,
    input wire logic irq_ff,
    input wire logic rx_int_req_ff
);
    import unrf_pkg::*;
    logic [2:0] mask_q;
    unrf_data_t sb_q;
    logic sb_rd_d, req_d, held, ctl_wr, ld_en;
    assign ctl_wr = reg_wr && reg_addr == OFS_CTRL;
    assign ld_en = mask_q[IRQ_LOADED];
    // Mask mirror and buffer value seen while the flag stays set
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            mask_q <= 3'h0;
            sb_rd_d <= 1'b0;
            req_d <= 1'b0;
            held <= 1'b0;
            sb_q <= 8'h00;
        end else begin
            if (reg_wr && reg_addr == OFS_IRQ_MASK) begin
                mask_q <= reg_wdata[2:0];
            end
            sb_rd_d <= reg_rd && reg_addr == OFS_SER_BUF;
            req_d <= rx_int_req_ff;
            // A clear beside a same-cycle load keeps the flag but not the data
            if (!rx_int_req_ff || ctl_wr) begin
                held <= 1'b0;
            end else if (sb_rd_d && req_d) begin
                held <= 1'b1;
                sb_q <= reg_rdata_ff;
            end
        end
    end
    ////////////////////////////////////////
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);
    property p_rd_idle;
        !reg_rd |=> reg_rdata_ff == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("rdata not idle");
    property p_unmapped;
        reg_rd && reg_addr > OFS_IRQ_MASK |=> reg_rdata_ff == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not 0");
    property p_flag_rd;
        reg_rd && reg_addr == OFS_CTRL |=>
            reg_rdata_ff[CTRL_FLAG] == $past(rx_int_req_ff);
    endproperty
    a_flag_rd: assert property (p_flag_rd) else $error("flag read");
    property p_req_hold;
        rx_int_req_ff && !ctl_wr |=> rx_int_req_ff;
    endproperty
    a_req_hold: assert property (p_req_hold) else $error("req hold");
    property p_sw_set;
        ctl_wr && reg_wdata[CTRL_FLAG] |=> rx_int_req_ff;
    endproperty
    a_sw_set: assert property (p_sw_set) else $error("flag set");
    property p_irq_masked;
        mask_q == 3'h0 [*2] |-> !irq_ff;
    endproperty
    a_irq_masked: assert property (p_irq_masked) else $error("irq masked");
    property p_irq_load;
        $rose(rx_int_req_ff) && !$past(ctl_wr) && $past(ld_en) |-> irq_ff;
    endproperty
    a_irq_load: assert property (p_irq_load) else $error("irq load");
    property p_serial_buffer_kept;
        sb_rd_d && held && req_d && rx_int_req_ff |-> reg_rdata_ff == sb_q;
    endproperty
    a_serial_buffer_kept: assert property (p_serial_buffer_kept) else $error("serial_buffer");
endmodule
bind unrf_rx_filter unrf_rx_filter_assertions chk (.core_clk(core_clk),
    .reset_n(reset_n), .rxd(rxd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff),
    .rx_int_req_ff(rx_int_req_ff));
`default_nettype wire

// >>> dv/unrf_rx_filter_test.sv
// Self-checking bench of the nine-bit receive filter.
// Assumes the remote transmitter model and one tick per clock.
`timescale 1ns/10ps
`default_nettype none
module unrf_rx_filter_test;
    import unrf_pkg::*;
    logic core_clk, reset_n, rxd, reg_wr, reg_rd, irq_ff, rx_int_req_ff;
    unrf_addr_t reg_addr;
    unrf_data_t reg_wdata, reg_rdata_ff, sb, st;
    logic nb;
    logic rd_seen = 1'b0;
    logic [2:0] mask;
    int errors, n_compared;
    unrf_data_t expq[$];
    // Frames as {ctrl, ninth bit, loaded}
    logic [9:0] tbl [10] = '{10'h2c0, 10'h2c3, 10'h2c6, 10'h241, 10'h3c3,
        10'h3c0, 10'h0c1, 10'h1c0, 10'h1c3, 10'h141};
    unrf_rx_filter DUT (.core_clk(core_clk), .reset_n(reset_n), .rxd(rxd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .irq_ff(irq_ff),
        .rx_int_req_ff(rx_int_req_ff));
    unrf_remote_tx tx (.core_clk(core_clk), .rxd(rxd));
    ////////////////////////////////////////
    task automatic check(input string what, input unrf_data_t seen, exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // One bus cycle; a read notes its expected data
    task automatic bus(input logic w, unrf_addr_t a, unrf_data_t v);
        if (!w)
            expq.push_back(v);
        reg_wr <= w;
        reg_rd <= !w;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge core_clk);
    endtask
    task automatic cyc(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge core_clk);
    endtask
    task automatic frame(input logic [9:0] t);
        unrf_data_t c, d;
        logic ld;
        c = t[9:2];
        ld = t[0];
        d = unrf_data_t'($urandom);
        bus(1, OFS_CTRL, c);
        bus(0, OFS_SER_BUF, sb);
        cyc(1);
        tx.send(d, t[1]);
        if (ld) begin
            sb = d;
            nb = t[1];
        end
        st = ld ? 8'h01 : 8'h02;
        check("irq", {7'h0, irq_ff}, {7'h0, |(st[2:0] & mask)});
        check("req", {7'h0, rx_int_req_ff}, {7'h0, ld | c[0]});
        bus(0, OFS_SER_BUF, sb);
        bus(0, OFS_IRQ_STAT, st);
        if (c[7])
            bus(0, OFS_CTRL, {c[7:4], 1'b0, nb, 1'b0, ld | c[0]});
        cyc(2);
        check("irq", {7'h0, irq_ff}, 8'h00);
        $display("frame with ctrl %h done", c);
    endtask
    // Read data stands one cycle after the strobe
    always @(posedge core_clk)
        rd_seen <= reg_rd;
    always @(negedge core_clk)
        if (rd_seen)
            check("rdata", reg_rdata_ff, expq.pop_front());
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        $display("Error watchdog expected end seen hang");
        tally_and_finish;
    end
    initial begin
        reset_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = '0;
        reg_wdata = '0;
        sb = SER_BUF_RST;
        nb = 1'b0;
        mask = 3'h0;
        errors = 0;
        n_compared = 0;
        void'($urandom(32'h59f203c9));
        repeat (2) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        check("irq", {7'h0, irq_ff}, 8'h00);
        check("req", {7'h0, rx_int_req_ff}, 8'h00);
        bus(0, OFS_CTRL, CTRL_RST);
        bus(0, OFS_SER_BUF, SER_BUF_RST);
        bus(0, OFS_IRQ_MASK, {5'h0, IRQ_MASK_RST});
        bus(0, OFS_IRQ_STAT, 8'h00);
        bus(1, 3'h7, 8'hff);
        bus(0, 3'h7, 8'h00);
        bus(0, OFS_BAUD_LO, BAUD_DIV_RST[7:0]);
        bus(0, OFS_BAUD_HI, BAUD_DIV_RST[15:8]);
        bus(1, OFS_BAUD_LO, 8'h00);
        bus(1, OFS_BAUD_HI, 8'h00);
        bus(0, OFS_BAUD_HI, 8'h00);
        bus(1, OFS_IRQ_MASK, 8'h07);
        bus(0, OFS_IRQ_MASK, 8'h07);
        mask = 3'h7;
        cyc(1);
        $display("reset values and map done");
        foreach (tbl[i])
            frame(tbl[i]);
        // Receiver off: a whole frame must leave no trace
        bus(1, OFS_CTRL, 8'h80);
        cyc(1);
        tx.send(unrf_data_t'($urandom), 1'b1);
        bus(0, OFS_IRQ_STAT, 8'h00);
        bus(0, OFS_SER_BUF, sb);
        cyc(1);
        check("req", {7'h0, rx_int_req_ff}, 8'h00);
        $display("receiver off done");
        bus(1, OFS_CTRL, 8'h90);
        cyc(1);
        tx.glitch(3);
        bus(0, OFS_IRQ_STAT, 8'h04);
        bus(1, OFS_IRQ_MASK, 8'h00);
        cyc(1);
        $display("start reject done");
        mask = 3'h0;
        frame(10'h241);
        tally_and_finish;
    end
endmodule
`default_nettype wire
